// File: sft_regs.vh
// register offsets, field positions, reset values and tick counts of the sent transmitter
`ifndef SFT_REGS_VH
`define SFT_REGS_VH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SFT_ADDR_W 8
`define SFT_OFS_CTRL 8'h00
`define SFT_OFS_TICK 8'h04
`define SFT_OFS_PAUSE 8'h08
`define SFT_OFS_SERIAL 8'h0c
`define SFT_OFS_TRIG 8'h10
`define SFT_OFS_STATUS 8'h14

// ****************************************
// control fields and register reset values
// ****************************************
`define SFT_CTRL_MODE_LSB 0
`define SFT_CTRL_PAUSE_BIT 2
`define SFT_CTRL_SERIAL_BIT 3
`define SFT_CTRL_DRIVE_LSB 4
`define SFT_CTRL_ADDR_LSB 6
`define SFT_CTRL_RST 8'h00
`define SFT_TICK_RST 8'h0f
`define SFT_PAUSE_RST 8'h00

// ****************************************
// frame modes
// ****************************************
`define SFT_MODE_FREE 2'h0
`define SFT_MODE_TRIG 2'h1
`define SFT_MODE_ADDR 2'h2
`define SFT_MODE_POLL 2'h3

// ****************************************
// tick counts, crc seed, last symbol index and reply bit count
// ****************************************
`define SFT_SYNC_TICKS 8'h38
`define SFT_LOW_TICKS 8'h05
`define SFT_HIGH_BASE 8'h07
`define SFT_MIN_PAUSE 8'h0c
`define SFT_CRC_SEED 4'h5
`define SFT_LAST_SYM 3'h6
`define SFT_REPLY_BITS 5'h10

`endif

// File: sft_sent_tx.v
// sent frame transmitter with manchester read reply on the same output pin
//
// Chosen here: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "sft_regs.vh"

// Functional notes
// - measured angle is sent as unsigned 12-bit code 0 to 4095 in payload.
// - frame mode chosen from free-streaming, triggered or shared via configuration.
// - free-streaming mode sends standard frames back to back without prompting.
// - triggered mode samples angle and sends one frame only on controller request.
// - shared line: answer only when addressed, or in turn when polled.
// - each nibble is a low interval then a high interval; low delimits nibbles.
// - low interval of every nibble is exactly 5 ticks.
// - high interval length encodes the nibble's four-bit value.
// - falling edge slew rate selected from drive-strength setting.
// - tick period programmable; nibble length is low plus high ticks.
// - frame order is sync, status, data nibbles, crc, optional pause.
// - status nibble carries status; serial channel bits only when enabled.
// - optional pause pulse after each frame fills gap to next frame.
// - manchester bit rate set by controller, 4 to 50 kbps; device adapts.
// - read reply starts between one half and three quarters bit after command.
// - high interval is 7 ticks for zero up to 22 ticks for fifteen.
// - access command abandons frames for manchester replies; exit restores frames.
// - manchester rising mid-bit edge is zero, falling is one, msb first.
module sft_sent_tx (
    input wire clk_i,
    input wire rstn_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [7:0] rdata_o,
    input wire [11:0] angle_i,
    input wire [1:0] status_i,
    input wire frame_req_i,
    input wire [1:0] req_addr_i,
    input wire poll_i,
    input wire man_access_i,
    input wire man_exit_i,
    input wire man_read_end_i,
    input wire [15:0] man_bit_cycles_i,
    input wire [15:0] reply_data_i,
    output reg sent_o,
    output reg [1:0] slew_o,
    output reg man_mode_o
);

    // ****************************************
    // states
    // ****************************************
    localparam [4:0] ST_IDLE = 5'b00001;
    localparam [4:0] ST_FRAME = 5'b00010;
    localparam [4:0] ST_MAN = 5'b00100;
    localparam [4:0] ST_MDLY = 5'b01000;
    localparam [4:0] ST_MTX = 5'b10000;

    reg [4:0] state;
    reg [7:0] ctrl;
    reg [7:0] tick_div;
    reg [7:0] pause_ticks;
    reg [7:0] serial_data;
    reg trig_pend;
    reg [1:0] poll_slot;
    reg [7:0] div_cnt;
    // decoded from the counter so the first tick of a frame is not one clock late
    wire tick = (state == ST_FRAME) && (div_cnt == tick_div);
    reg [7:0] seg_cnt;
    reg [2:0] sym_idx;
    reg [3:0] serial_pos;
    reg [3:0] nib [0:4];
    reg [15:0] reply;
    reg [4:0] reply_bit;
    reg reply_half;
    reg [15:0] man_cnt;
    reg [15:0] half_len;
    reg [3:0] next_status;
    reg [3:0] next_crc;
    reg [7:0] sym_len;
    reg start_ok;
    integer i;

    wire [1:0] mode = ctrl[`SFT_CTRL_MODE_LSB+1:`SFT_CTRL_MODE_LSB];
    wire [1:0] own_addr = ctrl[`SFT_CTRL_ADDR_LSB+1:`SFT_CTRL_ADDR_LSB];
    wire sym_end = tick && (seg_cnt == sym_len - 8'h01);
    wire frame_end = sym_end && (sym_idx == (ctrl[`SFT_CTRL_PAUSE_BIT] ? `SFT_LAST_SYM : 3'h5));

    // crc4 lookup for polynomial x4+x3+x2+1
    function [3:0] crc_step;
        input [3:0] crc;
        begin
            case (crc)
                4'h0: crc_step = 4'h0;
                4'h1: crc_step = 4'hd;
                4'h2: crc_step = 4'h7;
                4'h3: crc_step = 4'ha;
                4'h4: crc_step = 4'he;
                4'h5: crc_step = 4'h3;
                4'h6: crc_step = 4'h9;
                4'h7: crc_step = 4'h4;
                4'h8: crc_step = 4'h1;
                4'h9: crc_step = 4'hc;
                4'ha: crc_step = 4'h6;
                4'hb: crc_step = 4'hb;
                4'hc: crc_step = 4'hf;
                4'hd: crc_step = 4'h2;
                4'he: crc_step = 4'h8;
                default: crc_step = 4'h5;
            endcase
        end
    endfunction

    // ****************************************
    // frame content
    // ****************************************
    always @*
    begin
        next_status = {2'h0, status_i};
        if (ctrl[`SFT_CTRL_SERIAL_BIT])
        begin
            next_status[3] = (serial_pos == 4'h0);
            next_status[2] = serial_data[serial_pos[2:0]];
        end
        next_crc = `SFT_CRC_SEED;
        next_crc = crc_step(next_crc) ^ next_status;
        next_crc = crc_step(next_crc) ^ angle_i[11:8];
        next_crc = crc_step(next_crc) ^ angle_i[7:4];
        next_crc = crc_step(next_crc) ^ angle_i[3:0];
        next_crc = crc_step(next_crc);
    end

    always @*
    begin
        if (sym_idx == 3'h0)
            sym_len = `SFT_SYNC_TICKS;
        else if (sym_idx == `SFT_LAST_SYM)
            sym_len = (pause_ticks < `SFT_MIN_PAUSE) ? `SFT_MIN_PAUSE : pause_ticks;
        // 12 plus value ticks per nibble
        else
            sym_len = `SFT_LOW_TICKS + `SFT_HIGH_BASE + {4'h0, nib[sym_idx - 3'h1]};
    end

    always @*
    begin
        case (mode)
            `SFT_MODE_FREE: start_ok = 1'b1;
            `SFT_MODE_TRIG: start_ok = trig_pend;
            `SFT_MODE_ADDR: start_ok = frame_req_i && (req_addr_i == own_addr);
            default: start_ok = poll_i && (poll_slot == own_addr);
        endcase
    end

    // ****************************************
    // register port
    // ****************************************
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl <= `SFT_CTRL_RST;
            tick_div <= `SFT_TICK_RST;
            pause_ticks <= `SFT_PAUSE_RST;
            serial_data <= 8'h00;
            rdata_o <= 8'h00;
        end
        else
        begin
            if (wr_i)
            begin
                case (addr_i)
                    `SFT_OFS_CTRL: ctrl <= wdata_i;
                    `SFT_OFS_TICK: tick_div <= wdata_i;
                    `SFT_OFS_PAUSE: pause_ticks <= wdata_i;
                    `SFT_OFS_SERIAL: serial_data <= wdata_i;
                    default: ;
                endcase
            end
            if (rd_i)
            begin
                case (addr_i)
                    `SFT_OFS_CTRL: rdata_o <= ctrl;
                    `SFT_OFS_TICK: rdata_o <= tick_div;
                    `SFT_OFS_PAUSE: rdata_o <= pause_ticks;
                    `SFT_OFS_SERIAL: rdata_o <= serial_data;
                    `SFT_OFS_STATUS: rdata_o <= {trig_pend, poll_slot, state};
                    default: rdata_o <= 8'h00;
                endcase
            end
            else
                rdata_o <= 8'h00;
        end
    end

    // ****************************************
    // tick divider
    // ****************************************
    // divide clock by tick_div+1
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            div_cnt <= 8'h00;
        else if (state != ST_FRAME)
            // restart so the first tick of a frame is a whole tick long
            div_cnt <= 8'h00;
        else
            div_cnt <= (div_cnt == tick_div) ? 8'h00 : div_cnt + 8'h01;
    end

    // ****************************************
    // frame and reply sequencer
    // ****************************************
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state <= ST_IDLE;
            trig_pend <= 1'b0;
            poll_slot <= 2'h0;
            seg_cnt <= 8'h00;
            sym_idx <= 3'h0;
            serial_pos <= 4'h0;
            for (i = 0; i < 5; i = i + 1)
                nib[i] <= 4'h0;
            reply <= 16'h0000;
            reply_bit <= 5'h00;
            reply_half <= 1'b0;
            man_cnt <= 16'h0000;
            half_len <= 16'h0000;
            sent_o <= 1'b1;
            slew_o <= 2'h0;
            man_mode_o <= 1'b0;
        end
        else
        begin
            slew_o <= ctrl[`SFT_CTRL_DRIVE_LSB+1:`SFT_CTRL_DRIVE_LSB];
            // request flag, set wins over consume
            if (frame_req_i || (wr_i && addr_i == `SFT_OFS_TRIG))
                trig_pend <= 1'b1;
            else if (state == ST_IDLE && mode == `SFT_MODE_TRIG)
                trig_pend <= 1'b0;
            if (poll_i)
                poll_slot <= poll_slot + 2'h1;
            if (man_access_i && !man_mode_o)
            begin
                state <= ST_MAN;
                man_mode_o <= 1'b1;
                sent_o <= 1'b1;
            end
            else if (man_exit_i && man_mode_o)
            begin
                state <= ST_IDLE;
                man_mode_o <= 1'b0;
                sent_o <= 1'b1;
            end
            else
            begin
                case (state)
                    ST_IDLE:
                    begin
                        sent_o <= 1'b1;
                        if (start_ok)
                        begin
                            nib[0] <= next_status;
                            nib[1] <= angle_i[11:8];
                            nib[2] <= angle_i[7:4];
                            nib[3] <= angle_i[3:0];
                            nib[4] <= next_crc;
                            seg_cnt <= 8'h00;
                            sym_idx <= 3'h0;
                            state <= ST_FRAME;
                        end
                    end
                    ST_FRAME:
                    begin
                        sent_o <= (seg_cnt >= `SFT_LOW_TICKS);
                        if (sym_end)
                        begin
                            seg_cnt <= 8'h00;
                            sym_idx <= sym_idx + 3'h1;
                            if (frame_end)
                            begin
                                state <= ST_IDLE;
                                serial_pos <= serial_pos + 4'h1;
                            end
                        end
                        else if (tick)
                            seg_cnt <= seg_cnt + 8'h01;
                    end
                    ST_MAN:
                    begin
                        sent_o <= 1'b1;
                        if (man_read_end_i)
                        begin
                            reply <= reply_data_i;
                            half_len <= {1'b0, man_bit_cycles_i[15:1]};
                            // wait five eighths of a bit
                            man_cnt <= (man_bit_cycles_i >> 1) + (man_bit_cycles_i >> 3);
                            state <= ST_MDLY;
                        end
                    end
                    ST_MDLY:
                    begin
                        sent_o <= 1'b1;
                        if (man_cnt <= 16'h0001)
                        begin
                            reply_bit <= 5'h00;
                            reply_half <= 1'b0;
                            man_cnt <= half_len;
                            state <= ST_MTX;
                        end
                        else
                            man_cnt <= man_cnt - 16'h0001;
                    end
                    ST_MTX:
                    begin
                        // one is high then low, msb first
                        sent_o <= reply[15] ^ reply_half;
                        if (man_cnt <= 16'h0001)
                        begin
                            man_cnt <= half_len;
                            reply_half <= ~reply_half;
                            if (reply_half)
                            begin
                                reply <= {reply[14:0], 1'b0};
                                reply_bit <= reply_bit + 5'h01;
                                if (reply_bit == `SFT_REPLY_BITS - 5'h01)
                                    state <= ST_MAN;
                            end
                        end
                        else
                            man_cnt <= man_cnt - 16'h0001;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule // sft_sent_tx

// File: sft_checker.sv
// concurrent checks on the sent transmitter ports
`timescale 1ns/1ps
// ****************************************
// port checker
// ****************************************
module sft_checker (
    input wire clk_i,
    input wire rstn_i,
    input wire [7:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] rdata_o,
    input wire man_access_i,
    input wire man_exit_i,
    input wire man_read_end_i,
    input wire [15:0] man_bit_cycles_i,
    input wire [15:0] reply_data_i,
    input wire sent_o,
    input wire [1:0] slew_o,
    input wire man_mode_o
);
    // reset divider; the bench never rewrites it, so tick length stays fixed
    localparam int TK = 16;
    logic [15:0] low_cnt, hi_cnt, rd_cnt, bitp;
    logic msb, arm, seen;
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            low_cnt <= 16'h0;
            hi_cnt <= 16'h0;
            rd_cnt <= 16'h0;
            bitp <= 16'h0;
            msb <= 1'b0;
            arm <= 1'b0;
            seen <= 1'b0;
        end
        else
        begin
            low_cnt <= sent_o ? 16'h0 : low_cnt + 16'h1;
            hi_cnt <= sent_o ? hi_cnt + 16'h1 : 16'h0;
            rd_cnt <= man_read_end_i ? 16'h1 : rd_cnt + 16'h1;
            bitp <= man_read_end_i ? man_bit_cycles_i : bitp;
            msb <= man_read_end_i ? reply_data_i[15] : msb;
            arm <= (man_read_end_i & man_mode_o) | (arm & sent_o);
            // the first high after reset or exit is idle, not a nibble
            seen <= !man_mode_o & (seen | !sent_o);
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    property p_low_five;
        $rose(sent_o) && !man_mode_o |-> low_cnt == 16'(5 * TK);
    endproperty
    a_low_five: assert property (p_low_five) else $error("low interval wrong");
    property p_high_min;
        $fell(sent_o) && seen && !man_mode_o |-> hi_cnt >= 16'(7 * TK);
    endproperty
    a_high_min: assert property (p_high_min) else $error("high interval short");
    property p_access;
        man_access_i |=> man_mode_o;
    endproperty
    a_access: assert property (p_access) else $error("access not taken");
    property p_exit;
        man_exit_i && !man_access_i |=> !man_mode_o;
    endproperty
    a_exit: assert property (p_exit) else $error("exit not taken");
    property p_man_quiet;
        $rose(man_mode_o) |-> ##1 sent_o [*2];
    endproperty
    a_man_quiet: assert property (p_man_quiet) else $error("frame not abandoned");
    property p_reply;
        $fell(sent_o) && arm |-> (msb ? (rd_cnt >= bitp && rd_cnt <= bitp + bitp / 4 + 16'h2)
            : (rd_cnt >= bitp / 2 && rd_cnt <= bitp / 2 + bitp / 4 + 16'h2));
    endproperty
    a_reply: assert property (p_reply) else $error("reply start out of window");
    property p_rdata_idle;
        !$past(rd_i) |-> rdata_o == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_slew_src;
        $changed(slew_o) |-> ($past(wr_i) && $past(addr_i) == 8'h00)
            || ($past(wr_i, 2) && $past(addr_i, 2) == 8'h00);
    endproperty
    a_slew_src: assert property (p_slew_src) else $error("slew moved alone");
    c_reply: cover property ($fell(sent_o) && arm);
    c_access: cover property (man_access_i);
    c_nibble: cover property ($rose(sent_o) && !man_mode_o);
endmodule // sft_checker

// File: sft_sent_rx.sv
// far-end receiver that logs each symbol length in ticks
`timescale 1ns/1ps
// ****************************************
// receiver model
// ****************************************
module sft_sent_rx #(parameter int TK = 16) (
    input wire clk_i,
    input wire line_i,
    input wire man_mode_i
);
    int syms[$];
    int len;
    logic prev;
    initial
    begin
        len = 0;
        prev = 1'b1;
    end
    always @(posedge clk_i)
    begin
        if (man_mode_i)
            len = 0;
        else if (prev && !line_i)
        begin
            // idle gaps shorter than one tick vanish in the division
            if (len > 0)
                syms.push_back(len / TK);
            len = 1;
        end
        else if (len > 0)
            len = len + 1;
        prev = line_i;
    end
endmodule // sft_sent_rx

// File: sft_sent_tx_tb.sv
// self-checking bench for the sent frame transmitter
`timescale 1ns/1ps
`include "sft_regs.vh"
// ****************************************
// bench top
// ****************************************
module sft_sent_tx_tb;
    logic clk_i, rstn_i, wr_i, rd_i, frame_req_i, poll_i;
    logic man_access_i, man_exit_i, man_read_end_i, sent_o, man_mode_o;
    logic [7:0] addr_i, wdata_i, rdata_o;
    logic [11:0] angle_i;
    logic [1:0] status_i, req_addr_i, slew_o;
    logic [15:0] man_bit_cycles_i, reply_data_i, got;
    int n_errors, num_checks, k;
    sft_sent_tx dut (.clk_i, .rstn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .angle_i,
        .status_i, .frame_req_i, .req_addr_i, .poll_i, .man_access_i, .man_exit_i,
        .man_read_end_i, .man_bit_cycles_i, .reply_data_i, .sent_o, .slew_o, .man_mode_o);
    sft_sent_rx rx (.clk_i, .line_i(sent_o), .man_mode_i(man_mode_o));
    initial
    begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    task results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", {8'h0, rdata_o}, {8'h0, exp});
    endtask
    task pulse(input int s);
        @(posedge clk_i);
        case (s)
            0: frame_req_i <= 1'b1;
            1: poll_i <= 1'b1;
            2: man_access_i <= 1'b1;
            3: man_exit_i <= 1'b1;
            default: man_read_end_i <= 1'b1;
        endcase
        @(posedge clk_i);
        {frame_req_i, poll_i, man_access_i, man_exit_i, man_read_end_i} <= 5'h0;
    endtask
    task wait_syms(input int n);
        int t;
        t = 0;
        while (rx.syms.size() < n && t < 30000)
        begin
            @(posedge clk_i);
            t++;
        end
        if (t == 30000)
        begin
            chk("symbol wait", 16'h0, 16'h1);
            results();
        end
    endtask
    task lvl(input logic v);
        int t;
        t = 0;
        while (sent_o !== v && t < 2000)
        begin
            @(posedge clk_i);
            t++;
        end
        if (t == 2000)
        begin
            chk("level wait", 16'h0, 16'h1);
            results();
        end
    endtask
    task frame_check(input logic [1:0] st, input int tail);
        logic [3:0] nib [5];
        logic [3:0] c;
        int i, j;
        nib = '{{2'b00, st}, angle_i[11:8], angle_i[7:4], angle_i[3:0], 4'h0};
        c = 4'h5;
        for (i = 0; i < 5; i++)
            for (j = 3; j >= 0; j--)
                c = {c[2:0], nib[i][j]} ^ (c[3] ? 4'hd : 4'h0);
        rx.syms.delete();
        wait_syms(16);
        // index 0 may belong to a frame sampled before the settings changed
        i = 1;
        while (rx.syms[i] != 56 && i < 8)
            i++;
        chk("sync", 16'(rx.syms[i]), 16'd56);
        for (j = 0; j < 4; j++)
            chk("nibble", 16'(rx.syms[i + 1 + j]), 16'(12 + nib[j]));
        chk("crc", 16'(rx.syms[i + 5]), 16'(12 + c));
        chk("tail", 16'(rx.syms[i + 6]), 16'(tail));
    endtask
    task gated(input logic [7:0] ctrl, input int bad, input logic [1:0] ba, input int good);
        wr(`SFT_OFS_CTRL, ctrl);
        repeat (3500) @(posedge clk_i);
        rx.syms.delete();
        req_addr_i <= ba;
        pulse(bad);
        repeat (3500) @(posedge clk_i);
        chk("quiet", 16'(rx.syms.size()), 16'h0);
        req_addr_i <= 2'h1;
        pulse(good);
        // index 0 holds the last nibble of the old frame plus the idle gap
        wait_syms(5);
        chk("sync", 16'(rx.syms[1]), 16'd56);
    endtask
    initial
    begin
        rstn_i = 1'b0;
        {wr_i, rd_i, frame_req_i, poll_i, man_access_i, man_exit_i, man_read_end_i} = 7'h0;
        addr_i = 8'h0;
        wdata_i = 8'h0;
        angle_i = 12'hf0a;
        status_i = 2'h1;
        req_addr_i = 2'h0;
        man_bit_cycles_i = 16'd4000;
        reply_data_i = 16'h5a3c;
        n_errors = 0;
        num_checks = 0;
        repeat (20) @(posedge clk_i);
        rstn_i <= 1'b1;
        rd(`SFT_OFS_CTRL, `SFT_CTRL_RST);
        rd(`SFT_OFS_TICK, `SFT_TICK_RST);
        rd(`SFT_OFS_PAUSE, `SFT_PAUSE_RST);
        rd(8'h20, 8'h00);
        $display("test registers done");
        frame_check(2'h1, 56);
        $display("test free frames done");
        wr(`SFT_OFS_CTRL, 8'h24);
        wr(`SFT_OFS_PAUSE, 8'h20);
        angle_i <= 12'h0ff;
        status_i <= 2'h2;
        rd(`SFT_OFS_CTRL, 8'h24);
        chk("slew", {14'h0, slew_o}, 16'h2);
        frame_check(2'h2, 32);
        $display("test pause done");
        gated(8'h01, 4, 2'h1, 0);
        gated(8'h42, 0, 2'h2, 0);
        gated(8'h43, 1, 2'h1, 1);
        $display("test triggered and shared done");
        wr(`SFT_OFS_CTRL, 8'h00);
        lvl(1'b0);
        lvl(1'b1);
        pulse(2);
        #1 chk("manchester mode", {15'h0, man_mode_o}, 16'h1);
        // one fixed bit period, no write or pulses
        pulse(4);
        // sample each first half: delay 5/8 bit plus a quarter bit
        repeat (3500) @(posedge clk_i);
        for (k = 0; k < 16; k++)
        begin
            #1 got[15 - k] = sent_o;
            repeat (4000) @(posedge clk_i);
        end
        chk("reply", got, 16'h5a3c);
        pulse(3);
        #1 chk("manchester mode", {15'h0, man_mode_o}, 16'h0);
        frame_check(2'h2, 56);
        $display("test manchester done");
        results();
    end
endmodule // sft_sent_tx_tb
bind sft_sent_tx sft_checker u_chk (.clk_i, .rstn_i, .addr_i, .wr_i, .rd_i, .rdata_o,
    .man_access_i, .man_exit_i, .man_read_end_i, .man_bit_cycles_i, .reply_data_i,
    .sent_o, .slew_o, .man_mode_o);
